// ===== src/lsr_regs.svh
`ifndef LSR_REGS_SVH
`define LSR_REGS_SVH
// ----------------------------------------
// frame identifiers and command codes
// ----------------------------------------
`define LSR_ID_READ 6'h3D
`define LSR_ID_PREP8 6'h3C
`define LSR_CMD_STATUS 7'h01
`define LSR_CMD_OTP 7'h02
`define LSR_APP_MARKER 8'h80
`define LSR_FILLER 8'hFF
`define LSR_MARK_BIT 7
// ----------------------------------------
// frame lengths and byte positions
// ----------------------------------------
`define LSR_LEN_PREP7 4'h2
`define LSR_LEN_PREP8 4'h8
`define LSR_D1 4'h0
`define LSR_D2 4'h1
`define LSR_D3 4'h2
`define LSR_D4 4'h3
`define LSR_D5 4'h4
`define LSR_D6 4'h5
`define LSR_D7 4'h6
`define LSR_D8 4'h7
`define LSR_CSUM_IDX 4'h8
`define LSR_ONES_NIBBLE 4'hF
`define LSR_SUM_RESET 8'h00
`endif

// ===== src/lsr_pkg.sv
package lsr_pkg;
    // controller states
    typedef enum logic [2:0] {
        LSR_IDLE = 3'b000,
        LSR_RX = 3'b001,
        LSR_FILL = 3'b010,
        LSR_ARMED = 3'b011,
        LSR_SEND = 3'b100
    } lsr_state_t;
    // which reply is prepared
    typedef enum logic [1:0] {
        LSR_K_NONE = 2'b00,
        LSR_K_FS1 = 2'b01,
        LSR_K_FS2 = 2'b10,
        LSR_K_OTP = 2'b11
    } lsr_kind_t;
endpackage

// ===== src/lsr_buf_if.sv
`timescale 1ns/10ps
// reply buffer port between controller and its memory
interface lsr_buf_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en,
        output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_en,
        input rd_addr, output rd_data);
endinterface

// ===== src/lsr_frame_buf.sv
`timescale 1ns/10ps
// ----------------------------------------
// reply frame memory, registered read
// ----------------------------------------
module lsr_frame_buf import lsr_pkg::*; #(
    parameter int DEPTH = 9
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    lsr_buf_if.mem bus
);
    logic [7:0] mem_reg [0:DEPTH-1]; // data bytes then checksum
    logic [7:0] rd_reg; // read data register

    // write port, no reset needed on storage
    always_ff @(posedge mclk_i) begin
        if (ce_i && bus.wr_en) begin
            mem_reg[bus.wr_addr] <= bus.wr_data;
        end
    end

    // read data comes out of a flop
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_reg <= 8'h00;
        end else if (ce_i && bus.rd_en) begin
            rd_reg <= mem_reg[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_reg;
endmodule // lsr_frame_buf

// ===== src/lsr_status_otp.sv
`timescale 1ns/10ps
`include "lsr_regs.svh"
// What this block does
// - otp reply reads the prepared segment
// - replies only on read identifier 0x3D
// - prepared data sent in following read frame
// - otp bytes 0..7 ascending, then checksum
// - first status reply packs drive and fault fields
// - second status reply packs positions and stall
// - reply only after valid preparing frame
// - serving status query clears latched flags
// - alternative long preparing frame with marker
module lsr_status_otp import lsr_pkg::*; #(
    parameter int OTP_AW = 8
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [6:0] node_addr_i,
    input wire logic [5:0] prep_id_i,
    input wire logic frame_start_i,
    input wire logic [5:0] frame_id_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_frame_ok_i,
    input wire logic rx_frame_err_i,
    input wire logic tx_req_i,
    output logic resp_active_o,
    output logic tx_valid_o,
    output logic [7:0] tx_byte_o,
    input wire logic [OTP_AW-4:0] otp_segment_i,
    output logic otp_rd_o,
    output logic [OTP_AW-1:0] otp_addr_o,
    input wire logic [7:0] otp_data_i,
    output logic flag_clear_o,
    input wire logic [3:0] run_current_i,
    input wire logic [3:0] hold_current_i,
    input wire logic [3:0] vel_max_i,
    input wire logic [3:0] vel_min_i,
    input wire logic accel_profile_select_i,
    input wire logic [1:0] microstep_resolution_i,
    input wire logic shaft_dir_i,
    input wire logic [3:0] accel_index_i,
    input wire logic [7:0] fault_flags_i,
    input wire logic [2:0] motion_state_i,
    input wire logic [4:0] switch_ovc_stall_i,
    input wire logic [3:0] link_errors_i,
    input wire logic [3:0] absolute_threshold_i,
    input wire logic [3:0] delta_threshold_i,
    input wire logic [15:0] current_position_i,
    input wire logic [15:0] target_position_i,
    input wire logic [10:0] safe_position_i,
    input wire logic [2:0] fullstep_detect_enable_i,
    input wire logic full_duty_flag_i,
    input wire logic [2:0] stall_trip_flags_i,
    input wire logic [2:0] sample_count_min_i,
    input wire logic full_duty_detect_enable_i,
    input wire logic pwm_jitter_enable_i
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_reg; // release synchroniser
    logic rst_n; // internal reset copy

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // state and storage
    // ----------------------------------------
    lsr_state_t state_reg; // controller state
    lsr_kind_t kind_reg; // prepared reply kind
    logic prep8_reg; // long preparing frame in progress
    logic [3:0] rx_cnt_reg; // received data bytes
    logic rx_good_reg; // fixed fields all matched
    logic [6:0] rx_cmd_reg; // captured command code
    logic [6:0] rx_addr_reg; // captured node address
    logic [OTP_AW-4:0] seg_reg; // segment latched at preparation
    logic [3:0] fill_idx_reg; // next byte to fetch
    logic wr_vld_reg; // fetched byte lands this cycle
    logic [3:0] wr_idx_reg; // its position
    logic [7:0] stat_byte_reg; // fetched status byte
    logic [7:0] sum_reg; // running checksum
    logic [3:0] tx_idx_reg; // next byte to send
    logic rd_pend_reg; // buffer read in flight
    logic [7:0] stat_byte; // status byte for fill_idx
    logic [7:0] wdata; // byte written to buffer
    logic csum_wr; // checksum write cycle
    logic [8:0] sum_wide; // sum with carry
    logic rx_accept; // preparing frame is for us
    logic send_done; // last byte read issued
    lsr_buf_if buf_bus ();

    lsr_frame_buf #(.DEPTH(9)) u_buf (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .bus(buf_bus.mem)
    );

    // ----------------------------------------
    // preparing frame decode
    // ----------------------------------------
    // checks each byte as it arrives, no frame copy kept
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt_reg <= 4'h0;
            rx_good_reg <= 1'b0;
            rx_cmd_reg <= 7'h00;
            rx_addr_reg <= 7'h00;
            prep8_reg <= 1'b0;
        end else if (ce_i) begin
            if (frame_start_i) begin
                rx_cnt_reg <= 4'h0;
                rx_good_reg <= 1'b1;
                prep8_reg <= (frame_id_i == `LSR_ID_PREP8);
            end else if (state_reg == LSR_RX && rx_byte_valid_i) begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                if (!prep8_reg) begin
                    // short form: command then address, both marked
                    if (rx_cnt_reg == `LSR_D1) begin
                        rx_cmd_reg <= rx_byte_i[6:0];
                    end else if (rx_cnt_reg == `LSR_D2) begin
                        rx_addr_reg <= rx_byte_i[6:0];
                    end
                    if (!rx_byte_i[`LSR_MARK_BIT]) begin
                        rx_good_reg <= 1'b0;
                    end
                end else begin
                    // long form: marker, command, address, filler
                    case (rx_cnt_reg)
                        `LSR_D1: begin
                            if (rx_byte_i != `LSR_APP_MARKER) begin
                                rx_good_reg <= 1'b0;
                            end
                        end
                        `LSR_D2: begin
                            rx_cmd_reg <= rx_byte_i[6:0];
                            if (!rx_byte_i[`LSR_MARK_BIT]) begin
                                rx_good_reg <= 1'b0;
                            end
                        end
                        `LSR_D3: begin
                            rx_addr_reg <= rx_byte_i[6:0];
                            if (!rx_byte_i[`LSR_MARK_BIT]) begin
                                rx_good_reg <= 1'b0;
                            end
                        end
                        default: begin
                            if (rx_byte_i != `LSR_FILLER) begin
                                rx_good_reg <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // length, command and address all have to fit
    assign rx_accept = rx_frame_ok_i && rx_good_reg
        && (rx_cnt_reg == (prep8_reg ? `LSR_LEN_PREP8 : `LSR_LEN_PREP7))
        && (rx_cmd_reg == `LSR_CMD_STATUS || rx_cmd_reg == `LSR_CMD_OTP)
        && (rx_addr_reg == node_addr_i);

    assign send_done = tx_req_i && (tx_idx_reg == `LSR_CSUM_IDX);

    // ----------------------------------------
    // controller state
    // ----------------------------------------
    // a new preparing header wins in idle, fill and armed, dropping any pending reply; during send any header aborts to idle
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LSR_IDLE;
            kind_reg <= LSR_K_NONE;
            seg_reg <= '0;
        end else if (ce_i) begin
            case (state_reg)
                LSR_IDLE, LSR_FILL, LSR_ARMED: begin
                    if (frame_start_i && (frame_id_i == prep_id_i
                        || frame_id_i == `LSR_ID_PREP8)) begin
                        state_reg <= LSR_RX;
                        kind_reg <= LSR_K_NONE;
                    end else if (state_reg == LSR_ARMED && frame_start_i
                        && frame_id_i == `LSR_ID_READ) begin
                        state_reg <= LSR_SEND;
                    end else if (state_reg == LSR_FILL && csum_wr) begin
                        state_reg <= LSR_ARMED;
                    end
                end
                LSR_RX: begin
                    if (rx_accept) begin
                        state_reg <= LSR_FILL;
                        seg_reg <= otp_segment_i;
                        kind_reg <= (rx_cmd_reg == `LSR_CMD_OTP) ? LSR_K_OTP : LSR_K_FS1;
                    end else if (rx_frame_ok_i || rx_frame_err_i) begin
                        state_reg <= LSR_IDLE;
                    end
                end
                LSR_SEND: begin
                    if (frame_start_i || rx_frame_err_i) begin
                        state_reg <= LSR_IDLE;
                        kind_reg <= LSR_K_NONE;
                    end else if (send_done && kind_reg == LSR_K_FS1) begin
                        // second status reply is optional for the master
                        state_reg <= LSR_FILL;
                        kind_reg <= LSR_K_FS2;
                    end else if (send_done) begin
                        state_reg <= LSR_IDLE;
                        kind_reg <= LSR_K_NONE;
                    end
                end
                default: begin
                    state_reg <= LSR_IDLE;
                end
            endcase
        end
    end

    // latched flags are cleared once the first status reply went out
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            flag_clear_o <= 1'b0;
        end else if (ce_i) begin
            flag_clear_o <= (state_reg == LSR_SEND) && send_done
                && !frame_start_i && !rx_frame_err_i && kind_reg == LSR_K_FS1;
        end
    end

    // ----------------------------------------
    // reply assembly
    // ----------------------------------------
    always_comb begin
        stat_byte = {1'b1, node_addr_i};
        if (kind_reg == LSR_K_FS1) begin
            case (fill_idx_reg)
                `LSR_D2: stat_byte = {run_current_i, hold_current_i};
                `LSR_D3: stat_byte = {vel_max_i, vel_min_i};
                `LSR_D4: stat_byte = {accel_profile_select_i, microstep_resolution_i,
                    shaft_dir_i, accel_index_i};
                `LSR_D5: stat_byte = fault_flags_i;
                `LSR_D6: stat_byte = {motion_state_i, switch_ovc_stall_i};
                `LSR_D7: stat_byte = {`LSR_ONES_NIBBLE, link_errors_i};
                `LSR_D8: stat_byte = {absolute_threshold_i, delta_threshold_i};
                default: stat_byte = {1'b1, node_addr_i};
            endcase
        end else begin
            case (fill_idx_reg)
                `LSR_D2: stat_byte = current_position_i[15:8];
                `LSR_D3: stat_byte = current_position_i[7:0];
                `LSR_D4: stat_byte = target_position_i[15:8];
                `LSR_D5: stat_byte = target_position_i[7:0];
                `LSR_D6: stat_byte = safe_position_i[7:0];
                `LSR_D7: stat_byte = {fullstep_detect_enable_i, 1'b1, full_duty_flag_i,
                    safe_position_i[10:8]};
                `LSR_D8: stat_byte = {stall_trip_flags_i, sample_count_min_i,
                    full_duty_detect_enable_i, pwm_jitter_enable_i};
                default: stat_byte = {1'b1, node_addr_i};
            endcase
        end
    end

    // otp data arrives one cycle after the request, status is held
    assign wdata = csum_wr ? ~sum_reg : (kind_reg == LSR_K_OTP ? otp_data_i : stat_byte_reg);
    assign csum_wr = state_reg == LSR_FILL && fill_idx_reg == `LSR_CSUM_IDX && !wr_vld_reg;
    assign sum_wide = {1'b0, sum_reg} + {1'b0, wdata};
    assign otp_rd_o = state_reg == LSR_FILL && kind_reg == LSR_K_OTP
        && fill_idx_reg < `LSR_CSUM_IDX;
    assign otp_addr_o = {seg_reg, fill_idx_reg[2:0]};

    // fetch one byte per cycle, then append checksum
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            fill_idx_reg <= 4'h0;
            wr_vld_reg <= 1'b0;
            wr_idx_reg <= 4'h0;
            stat_byte_reg <= 8'h00;
            sum_reg <= `LSR_SUM_RESET;
        end else if (ce_i) begin
            if (state_reg != LSR_FILL) begin
                fill_idx_reg <= `LSR_D1;
                wr_vld_reg <= 1'b0;
                sum_reg <= `LSR_SUM_RESET;
            end else begin
                wr_vld_reg <= fill_idx_reg < `LSR_CSUM_IDX;
                if (fill_idx_reg < `LSR_CSUM_IDX) begin
                    fill_idx_reg <= fill_idx_reg + 4'h1;
                    wr_idx_reg <= fill_idx_reg;
                    stat_byte_reg <= stat_byte;
                end
                if (wr_vld_reg) begin
                    // end-around carry sum
                    sum_reg <= sum_wide[7:0] + {7'h00, sum_wide[8]};
                end
            end
        end
    end

    assign buf_bus.wr_en = state_reg == LSR_FILL && (wr_vld_reg || csum_wr);
    assign buf_bus.wr_addr = csum_wr ? `LSR_CSUM_IDX : wr_idx_reg;
    assign buf_bus.wr_data = wdata;

    // ----------------------------------------
    // response transmit
    // ----------------------------------------
    assign buf_bus.rd_en = state_reg == LSR_SEND && tx_req_i;
    assign buf_bus.rd_addr = tx_idx_reg;
    assign resp_active_o = state_reg == LSR_SEND;
    assign tx_byte_o = buf_bus.rd_data;
    assign tx_valid_o = rd_pend_reg;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_idx_reg <= 4'h0;
            rd_pend_reg <= 1'b0;
        end else if (ce_i) begin
            rd_pend_reg <= buf_bus.rd_en;
            if (state_reg != LSR_SEND) begin
                tx_idx_reg <= `LSR_D1;
            end else if (tx_req_i) begin
                tx_idx_reg <= tx_idx_reg + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n || !ce_i);

    a_send_on_read: assert property ($rose(resp_active_o) |->
        $past(frame_start_i && frame_id_i == `LSR_ID_READ))
        else $error("reply started on wrong identifier");
    a_addr_match: assert property (state_reg == LSR_RX ##1 state_reg == LSR_FILL |->
        $past(rx_addr_reg) == $past(node_addr_i))
        else $error("reply prepared for other node");
    a_cmd_known: assert property (state_reg == LSR_RX ##1 state_reg == LSR_FILL |->
        $past(rx_cmd_reg) inside {`LSR_CMD_STATUS, `LSR_CMD_OTP})
        else $error("reply prepared for unknown command");
    a_otp_order: assert property (otp_rd_o && otp_addr_o[2:0] != 3'h0 |->
        $past(otp_rd_o) && $past(otp_addr_o) == otp_addr_o - 1'b1)
        else $error("otp bytes out of order");
    a_otp_segment: assert property (otp_rd_o |->
        otp_addr_o[OTP_AW-1:3] == seg_reg ##1 buf_bus.wr_data == otp_data_i)
        else $error("otp segment or data mismatch");
    a_first_mark: assert property (kind_reg != LSR_K_OTP && wr_vld_reg
        && wr_idx_reg == `LSR_D1 |-> buf_bus.wr_data == {1'b1, node_addr_i})
        else $error("status reply lacks address byte");
    a_fs2_one_bit: assert property (kind_reg == LSR_K_FS2 && wr_vld_reg
        && wr_idx_reg == `LSR_D7 |-> buf_bus.wr_data[4])
        else $error("second status byte seven malformed");
    a_flag_clear: assert property (flag_clear_o |->
        state_reg == LSR_FILL && kind_reg == LSR_K_FS2 && $past(state_reg) == LSR_SEND)
        else $error("flag clear outside first status reply");
    a_tx_follow: assert property (resp_active_o && tx_req_i |=> tx_valid_o)
        else $error("requested byte not delivered");

    c_otp_sent: cover property (kind_reg == LSR_K_OTP && send_done);
    c_fs2_sent: cover property (kind_reg == LSR_K_FS2 && send_done);
    c_fs2_skipped: cover property (kind_reg == LSR_K_FS2 && state_reg == LSR_ARMED
        && frame_start_i && (frame_id_i == prep_id_i || frame_id_i == `LSR_ID_PREP8));
endmodule // lsr_status_otp

// ===== tb/lsr_lin_master.sv
`timescale 1ns/10ps
`include "lsr_regs.svh"
// ----------------------------------------
// bus master stand-in, drives on falling edge
// ----------------------------------------
module lsr_lin_master (
    input wire logic mclk_i,
    input wire logic resp_active_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_byte_i,
    output logic frame_start_o,
    output logic [5:0] frame_id_o,
    output logic rx_byte_valid_o,
    output logic [7:0] rx_byte_o,
    output logic rx_frame_ok_o,
    output logic tx_req_o
);
    // quiet bus at time zero
    initial begin
        frame_start_o = 1'b0;
        frame_id_o = 6'h00;
        rx_byte_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        rx_frame_ok_o = 1'b0;
        tx_req_o = 1'b0;
    end
    // ----------------------------------------
    // preparing frame: header, n bytes, good checksum
    // ----------------------------------------
    task automatic send(input logic [5:0] id, input logic [7:0] b [8], input int n);
        @(negedge mclk_i) frame_start_o = 1'b1;
        frame_id_o = id;
        @(negedge mclk_i) frame_start_o = 1'b0;
        frame_id_o = ~id; // released id shows junk, not the old value
        for (int i = 0; i < n; i++) begin
            rx_byte_valid_o = 1'b1;
            rx_byte_o = b[i];
            @(negedge mclk_i) rx_byte_valid_o = 1'b0;
            rx_byte_o = ~b[i];
            @(negedge mclk_i);
        end
        rx_frame_ok_o = 1'b1;
        @(negedge mclk_i) rx_frame_ok_o = 1'b0;
    endtask
    // ----------------------------------------
    // reading frame: header, then pull nine bytes
    // ----------------------------------------
    task automatic read(output logic got, output logic [7:0] r [9]);
        @(negedge mclk_i) frame_start_o = 1'b1;
        frame_id_o = `LSR_ID_READ;
        @(negedge mclk_i) frame_start_o = 1'b0;
        frame_id_o = 6'h00;
        got = resp_active_i;
        for (int i = 0; i < 9; i++) begin
            r[i] = 8'hXX; // a missing byte never matches
            if (got === 1'b1) begin
                tx_req_o = 1'b1;
                @(negedge mclk_i) tx_req_o = 1'b0;
                if (tx_valid_i === 1'b1) r[i] = tx_byte_i;
                @(negedge mclk_i);
            end
        end
    endtask
endmodule // lsr_lin_master

// ===== tb/testbench.sv
`timescale 1ns/10ps
`include "lsr_regs.svh"
module testbench import lsr_pkg::*; ;
    localparam logic [5:0] PID = 6'h11; // short preparing frame id
    logic mclk;
    logic rst_n = 1'b0;
    logic [63:0] st; // first reply bytes 2..8 in wire order
    logic [63:0] ps; // second reply bytes 2..8 in wire order
    logic [6:0] node;
    logic [4:0] seg;
    logic [7:0] otp_q = 8'h00; // otp array read data
    logic [7:0] r [9];
    logic got, fs, bv, fok, treq, ract, tv, ord, fclr;
    logic [5:0] fid;
    logic [7:0] bd, txb, oad;
    int mismatches = 0;
    int check_count = 0;
    int clr_cnt = 0;
    int cyc = 0;
    int n;
    lsr_lin_master m (
        .mclk_i(mclk), .resp_active_i(ract), .tx_valid_i(tv), .tx_byte_i(txb),
        .frame_start_o(fs), .frame_id_o(fid), .rx_byte_valid_o(bv), .rx_byte_o(bd),
        .rx_frame_ok_o(fok), .tx_req_o(treq)
    );
    lsr_status_otp dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .node_addr_i(node), .prep_id_i(PID),
        .frame_start_i(fs), .frame_id_i(fid), .rx_byte_valid_i(bv), .rx_byte_i(bd),
        .rx_frame_ok_i(fok), .rx_frame_err_i(1'b0), .tx_req_i(treq), .resp_active_o(ract),
        .tx_valid_o(tv), .tx_byte_o(txb), .otp_segment_i(seg), .otp_rd_o(ord),
        .otp_addr_o(oad), .otp_data_i(otp_q), .flag_clear_o(fclr),
        .run_current_i(st[7:4]), .hold_current_i(st[3:0]), .vel_max_i(st[15:12]),
        .vel_min_i(st[11:8]), .accel_profile_select_i(st[23]),
        .microstep_resolution_i(st[22:21]), .shaft_dir_i(st[20]), .accel_index_i(st[19:16]),
        .fault_flags_i(st[31:24]), .motion_state_i(st[39:37]), .switch_ovc_stall_i(st[36:32]),
        .link_errors_i(st[43:40]), .absolute_threshold_i(st[55:52]),
        .delta_threshold_i(st[51:48]), .current_position_i({ps[7:0], ps[15:8]}),
        .target_position_i({ps[23:16], ps[31:24]}), .safe_position_i({ps[42:40], ps[39:32]}),
        .fullstep_detect_enable_i(ps[47:45]), .full_duty_flag_i(ps[43]),
        .stall_trip_flags_i(ps[55:53]), .sample_count_min_i(ps[52:50]),
        .full_duty_detect_enable_i(ps[49]), .pwm_jitter_enable_i(ps[48])
    );
    // ----------------------------------------
    // clock, otp array, flag-clear and hang watch
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [7:0] otp_val(logic [7:0] a);
        return {a[2:0], a[7:3]} ^ 8'hC3;
    endfunction
    // one-cycle read latency; idle data toggles so stale bytes show
    always @(posedge mclk) otp_q <= (ord === 1'b1) ? otp_val(oad) : ~otp_q;
    always @(posedge mclk) if (fclr === 1'b1) clr_cnt <= clr_cnt + 1;
    always @(negedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            mismatches++;
            close_out();
        end
    end
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [7:0] exp_byte(lsr_kind_t k, int i);
        logic [7:0] e;
        if (k == LSR_K_OTP) return otp_val({seg, i[2:0]});
        if (i == 0) return {1'b1, node};
        e = (k == LSR_K_FS1) ? st[8*(i-1) +: 8] : ps[8*(i-1) +: 8];
        if (k == LSR_K_FS1 && i == 6) e[7:4] = `LSR_ONES_NIBBLE;
        if (k == LSR_K_FS2 && i == 6) e[4] = 1'b1;
        return e;
    endfunction
    // inverted sum with end-around carry
    function automatic logic [7:0] csum(lsr_kind_t k);
        int s;
        s = 0;
        for (int i = 0; i < 8; i++) begin
            s = s + exp_byte(k, i);
            if (s > 255) s = s - 255;
        end
        return ~s[7:0];
    endfunction
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic prep(input logic [6:0] cmd, input logic [6:0] ad, input logic lng);
        logic [7:0] b [8];
        b = '{8'h80, {1'b1, cmd}, {1'b1, ad}, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        if (!lng) b = '{{1'b1, cmd}, {1'b1, ad}, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        m.send(lng ? `LSR_ID_PREP8 : PID, b, lng ? 8 : 2);
        repeat (16) @(negedge mclk); // reply fill time
    endtask
    task automatic reply(lsr_kind_t k);
        m.read(got, r);
        chk({7'h00, got}, 8'h01);
        for (int i = 0; i < 8; i++) chk(r[i], exp_byte(k, i));
        chk(r[8], csum(k));
    endtask
    task automatic silent();
        m.read(got, r);
        chk({7'h00, got}, 8'h00);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h1FE70DA6));
        st = 64'h0;
        ps = 64'h0;
        node = 7'h00;
        seg = 5'h00;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        silent();
        for (int it = 0; it < 4; it++) begin
            st = {$urandom, $urandom};
            ps = {$urandom, $urandom};
            node = 7'($urandom);
            seg = 5'($urandom);
            // corner: all-ones address and last segment
            if (it == 0) node = 7'h7F;
            if (it == 0) seg = 5'h1F;
            prep(`LSR_CMD_OTP, node, it[0]);
            reply(LSR_K_OTP);
            silent();
            n = clr_cnt;
            prep(`LSR_CMD_STATUS, node, ~it[0]);
            reply(LSR_K_FS1);
            repeat (16) @(negedge mclk);
            chk(8'(clr_cnt - n), 8'h01);
            // third pass leaves the second reply armed and unread
            if (it != 2) reply(LSR_K_FS2);
            $display("pass %0d done", it);
        end
        // foreign address, then an unknown command: both dropped
        prep(`LSR_CMD_OTP, ~node, 1'b0);
        silent();
        prep(7'h03, node, 1'b1);
        silent();
        $display("refusal cases done");
        close_out();
    end
endmodule // testbench
